// >>> hw/cmc_top.sv
// charger sequencing, mode selection, status pin and control registers
module cmc_top #(
	parameter int unsigned     P_DEGL_CYC  = cmc_pkg::DEGL_CYC,
	parameter int unsigned     P_DET_CYC   = cmc_pkg::DET_CYC,
	parameter int unsigned     P_EOC_CYC   = cmc_pkg::EOC_CYC,
	parameter int unsigned     P_PULSE_CYC = cmc_pkg::PULSE_CYC,
	parameter int unsigned     P_SLEW_CYC  = cmc_pkg::SLEW_CYC,
	parameter longint unsigned P_WDOG_CYC  = cmc_pkg::WDOG_CYC,
	parameter longint unsigned P_SAFE_CYC  = cmc_pkg::SAFE_CYC
) (
	// clock and reset
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_reset,
	// register port
	input  wire logic [cmc_pkg::AW-1:0] i_addr,
	input  wire logic [cmc_pkg::DW-1:0] i_wdata,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	output logic      [cmc_pkg::DW-1:0] o_rdata,
	// pins and analog comparators
	input  wire logic                  i_charge_disable_pin,
	input  wire logic                  i_limit_reset_pin,
	input  wire logic                  i_bat_below_short,
	input  wire logic                  i_bat_above_rch,
	input  wire logic                  i_term_current,
	input  wire logic                  i_bat_below_lowv,
	input  wire logic                  i_vbus_uvlo,
	input  wire logic                  i_temp_hot,
	input  wire logic                  i_temp_cool,
	input  wire logic                  i_ls_above_100ma,
	input  wire logic [4:0]            i_flt,
	// converter control
	output logic                       o_pwm_en,
	output logic                       o_low_side_switch,
	output logic                       o_short_mode,
	output logic                       o_discharge_en,
	output logic      [5:0]            o_regulation_voltage,
	output logic      [2:0]            o_charge_current,
	output logic      [1:0]            o_mode,
	output logic                       o_charge_done,
	// status pin, open drain
	output logic                       o_stat_out,
	output logic                       o_stat_oe
);
	import cmc_pkg::*;

	// ************************************************************
	// parameter check
	// ************************************************************
	if (P_DEGL_CYC < 1 || P_DET_CYC < 1 || P_EOC_CYC < 1 || P_PULSE_CYC < 1 ||
		P_SLEW_CYC < 1 || P_WDOG_CYC < 1 || P_SAFE_CYC < 1 || P_SAFE_CYC >= 64'h10_0000_0000) begin : g_chk
		$error("cmc_top: timing parameter out of range");
	end

	// ************************************************************
	// input synchronisers
	// ************************************************************
	localparam int NS = 15;
	// below-short assumed until the real pin level arrives, so the charger never
	// leaves the reduced current on a stale synchroniser value after reset
	localparam logic [NS-1:0] SYNC_RST = 15'h1000;
	logic [NS-1:0] meta_ff;      // first stage, read only by sync_ff
	logic [NS-1:0] sync_ff;      // second stage, safe to use

	// every pin crosses two flops before use
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			meta_ff <= SYNC_RST;
			sync_ff <= SYNC_RST;
		end else begin
			meta_ff <= {i_charge_disable_pin, i_limit_reset_pin, i_bat_below_short, i_bat_above_rch,
				i_term_current, i_bat_below_lowv, i_vbus_uvlo, i_temp_hot, i_temp_cool,
				i_ls_above_100ma, i_flt};
			sync_ff <= meta_ff;
		end
	end

	logic cd, lrst, bshort, rch, term, lowv, uvlo, hot_in, cool, ls100;
	logic sleep_f, ovp_f, poor_f, ovld_f, blow_f;
	assign {cd, lrst, bshort, rch, term, lowv, uvlo, hot_in, cool, ls100} = sync_ff[14:5];
	assign {blow_f, ovld_f, poor_f, ovp_f, sleep_f} = sync_ff[4:0];

	// ************************************************************
	// register file
	// ************************************************************
	logic [4:0]    ctrl_ff, nxt_ctrl;    // control bits
	logic [5:0]    vreg_ff, nxt_vreg;    // voltage code
	logic [2:0]    ichg_ff, nxt_ichg;    // current code
	logic [5:0]    limv_ff, nxt_limv;    // safety voltage cap
	logic [2:0]    limi_ff, nxt_limi;    // safety current cap
	logic          lock_ff, nxt_lock;    // safety limits locked
	logic [DW-1:0] rdata_ff, nxt_rdata;  // read data, one cycle late
	logic          restart;              // new charge cycle request
	logic          param_dflt;           // charger asks for defaults
	logic          flt_rd;               // fault register read
	logic [NF-1:0] fcap_ff;              // frozen fault bits
	logic [15:0]   stat_word;            // live status view

	always_comb begin
		nxt_ctrl  = ctrl_ff;
		nxt_vreg  = vreg_ff;
		nxt_ichg  = ichg_ff;
		nxt_limv  = limv_ff;
		nxt_limi  = limi_ff;
		nxt_lock  = lock_ff;
		nxt_rdata = '0;
		restart   = 1'b0;
		flt_rd    = i_rd && i_addr == A_FLT;
		// register writes
		if (i_wr) begin
			if (i_addr != A_LIMV && i_addr != A_LIMI)
				nxt_lock = 1'b1;
			case (i_addr)
				A_CTRL: begin
					nxt_ctrl = i_wdata[4:0];
					restart  = i_wdata[B_INH] != ctrl_ff[B_INH];
				end
				A_VREG: nxt_vreg = (i_wdata[5:0] > VREG_MAX) ? VREG_MAX : i_wdata[5:0];
				A_ICHG: nxt_ichg = i_wdata[2:0];
				A_LIMV: if (!lock_ff) nxt_limv = i_wdata[5:0];
				A_LIMI: if (!lock_ff) nxt_limi = i_wdata[2:0];
				default: ;
			endcase
		end
		// parameter reset bit is never stored, so it reads back zero
		if ((i_wr && i_addr == A_CTRL && i_wdata[B_PRST]) || param_dflt) begin
			nxt_ctrl = CTRL_RST;
			nxt_vreg = VREG_RST;
			nxt_ichg = ICHG_RST;
			// only the host bit restarts; defaults raised by the sequencer itself
			// must not feed back into the sequencer within the same cycle
			restart  = restart | (i_wr && i_addr == A_CTRL && i_wdata[B_PRST]);
		end
		// limit pin low overrides any write
		if (!lrst) begin
			nxt_limv = LIMV_RST;
			nxt_limi = LIMI_RST;
		end
		// read mux, unmapped reads give zero
		if (i_rd) begin
			case (i_addr)
				A_CTRL:  nxt_rdata = {11'h000, ctrl_ff};
				A_VREG:  nxt_rdata = {10'h000, vreg_ff};
				A_ICHG:  nxt_rdata = {13'h0000, ichg_ff};
				A_LIMV:  nxt_rdata = {10'h000, limv_ff};
				A_LIMI:  nxt_rdata = {13'h0000, limi_ff};
				A_STAT:  nxt_rdata = stat_word;
				A_FLT:   nxt_rdata = {7'h00, fcap_ff};
				default: nxt_rdata = '0;
			endcase
		end
	end

	// register state
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			ctrl_ff  <= CTRL_RST;
			vreg_ff  <= VREG_RST;
			ichg_ff  <= ICHG_RST;
			limv_ff  <= LIMV_RST;
			limi_ff  <= LIMI_RST;
			lock_ff  <= 1'b0;
			rdata_ff <= '0;
		end else begin
			ctrl_ff  <= nxt_ctrl;
			vreg_ff  <= nxt_vreg;
			ichg_ff  <= nxt_ichg;
			limv_ff  <= nxt_limv;
			limi_ff  <= nxt_limi;
			lock_ff  <= nxt_lock;
			rdata_ff <= nxt_rdata;
		end
	end

	// ************************************************************
	// charger sequencing, timers, status pin
	// ************************************************************
	cmc_state_e    st_ff, nxt_st;          // charge phase
	cmc_mode_e     mode;                   // resolved operating mode
	logic          hot_ff, nxt_hot;        // thermal shutdown latch
	logic          host_ff, nxt_host;      // host mode, watchdog running
	logic          tfault_ff, nxt_tfault;  // safety timer expired
	logic          nobat_ff, nxt_nobat;    // battery found absent
	logic          done_ff, nxt_done;      // charge complete shown
	logic [39:0]   tmr_ff, nxt_tmr;        // watchdog or 15 min timer
	logic [31:0]   ph_ff, nxt_ph;          // phase timer
	logic [31:0]   slew_ff, nxt_slew;      // ramp step timer
	logic [2:0]    cur_ff, nxt_cur;        // ramped current code
	logic [31:0]   pls_ff, nxt_pls;        // fault pulse counter
	logic [NF-1:0] fprev_ff;               // faults last cycle
	logic [NF-1:0] fcur, fsel;             // live and mode-masked faults
	logic          lock_flt_ff, nxt_lock_flt;
	logic [NF-1:0] nxt_fcap;
	logic          charging;               // charge mode, not hot, in S_SHORT through S_EOC
	logic [2:0]    tgt;                    // target current code

	assign fcur = {blow_f, ovld_f, hot_ff, nobat_ff, uvlo, poor_f, ovp_f, sleep_f, tfault_ff};
	assign charging = mode == M_CHARGE && !hot_ff && st_ff inside {S_SHORT, S_FAST, S_DET, S_EOC};
	assign stat_word = {8'h00, 1'b0, st_ff, mode, host_ff, done_ff};

	// mode from select bits, disable pin and faults
	always_comb begin
		if (cd || ctrl_ff[B_HZ] || (!ctrl_ff[B_OPS] && uvlo))
			mode = M_HIZ;
		else if (ctrl_ff[B_OPS])
			mode = |(fcur & BST_FLT_MASK) ? M_CONFIG : M_BOOST;
		else
			mode = |(fcur & CHG_FLT_MASK & ~(NF'(1) << F_NOBAT)) ? M_CONFIG : M_CHARGE;
		fsel = fcur & (ctrl_ff[B_OPS] ? BST_FLT_MASK : CHG_FLT_MASK);
	end

	always_comb begin
		nxt_st      = st_ff;
		nxt_host    = host_ff;
		nxt_tfault  = tfault_ff;
		nxt_nobat   = nobat_ff;
		nxt_done    = done_ff;
		nxt_tmr     = tmr_ff;
		nxt_ph      = ph_ff;
		nxt_slew    = slew_ff;
		nxt_cur     = cur_ff;
		param_dflt  = 1'b0;
		tgt         = host_ff ? ((ichg_ff > limi_ff) ? limi_ff : ichg_ff) : ICHG_RST;
		// shutdown latch with hysteresis via the cool comparator
		nxt_hot     = hot_in | (hot_ff & ~cool);
		// host watchdog and unattended timer, frozen while hot
		if (i_wr) begin
			nxt_host = 1'b1;
			nxt_tmr  = '0;
		end else if (!hot_ff) begin
			if (host_ff) begin
				nxt_tmr = tmr_ff + 40'h1;
				if (tmr_ff == 40'(P_WDOG_CYC - 1)) begin
					nxt_host   = 1'b0;
					nxt_tmr    = '0;
					param_dflt = 1'b1;
				end
			end else if (cd) begin
				nxt_tmr = '0;
			end else if (charging && !tfault_ff) begin
				nxt_tmr = tmr_ff + 40'h1;
				if (tmr_ff == 40'(P_SAFE_CYC - 1))
					nxt_tfault = 1'b1;
			end
		end
		// charge phases, held entirely while hot
		if (hot_ff) begin
			nxt_st = st_ff;
		end else if (mode != M_CHARGE || ctrl_ff[B_INH] || tfault_ff) begin
			nxt_st   = S_IDLE;
			nxt_cur  = '0;
			nxt_done = 1'b0;
		end else if (restart) begin
			nxt_st   = S_SHORT;
			nxt_done = 1'b0;
		end else begin
			case (st_ff)
				S_IDLE: begin
					nxt_nobat = 1'b0;
					nxt_ph    = '0;
					nxt_st    = (lowv || !rch) ? S_SHORT : S_DONE;
				end
				S_SHORT: begin
					nxt_cur = '0;
					nxt_ph  = '0;
					if (!bshort)
						nxt_st = S_FAST;
				end
				S_FAST: begin
					// step the current toward target at a fixed slew
					nxt_slew = slew_ff + 32'h1;
					if (slew_ff >= P_SLEW_CYC - 1) begin
						nxt_slew = '0;
						if (cur_ff < tgt)
							nxt_cur = cur_ff + 3'h1;
						else if (cur_ff > tgt)
							nxt_cur = cur_ff - 3'h1;
					end
					nxt_ph = rch ? ph_ff + 32'h1 : '0;
					if (bshort)
						nxt_st = S_SHORT;
					else if (ctrl_ff[B_TERM] && host_ff && term && ph_ff >= P_DEGL_CYC - 1) begin
						nxt_st = S_DET;
						nxt_ph = '0;
					end
				end
				S_DET: begin
					nxt_ph = ph_ff + 32'h1;
					if (ph_ff == P_DET_CYC - 1) begin
						nxt_ph = '0;
						if (rch) begin
							nxt_st = S_EOC;
						end else begin
							nxt_st     = S_IDLE;
							nxt_nobat  = 1'b1;
							param_dflt = 1'b1;
						end
					end
				end
				S_EOC: begin
					nxt_ph = ph_ff + 32'h1;
					if (ph_ff == P_EOC_CYC - 1) begin
						nxt_st   = S_DONE;
						nxt_done = 1'b1;
					end
				end
				S_DONE: begin
					if (!rch) begin
						nxt_st   = S_SHORT;
						nxt_done = 1'b0;
					end
				end
				default: nxt_st = S_IDLE;
			endcase
		end
		// new fault edge starts a pulse only when none is running
		if (pls_ff != 0)
			nxt_pls = pls_ff - 32'h1;
		else if (|(fsel & ~fprev_ff))
			nxt_pls = P_PULSE_CYC;
		else
			nxt_pls = '0;
		// fault capture frozen until read; a new fault wins over the read
		nxt_lock_flt = lock_flt_ff & ~flt_rd;
		nxt_fcap     = fcap_ff;
		if (!lock_flt_ff || flt_rd) begin
			nxt_fcap = fsel;
			if (|fsel)
				nxt_lock_flt = 1'b1;
		end
	end

	// charger state and outputs, all outputs from flops
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			st_ff                <= S_IDLE;
			hot_ff               <= 1'b0;
			host_ff              <= 1'b0;
			tfault_ff            <= 1'b0;
			nobat_ff             <= 1'b0;
			done_ff              <= 1'b0;
			tmr_ff               <= '0;
			ph_ff                <= '0;
			slew_ff              <= '0;
			cur_ff               <= '0;
			pls_ff               <= '0;
			fprev_ff             <= '0;
			fcap_ff              <= '0;
			lock_flt_ff          <= 1'b0;
			o_pwm_en             <= 1'b0;
			o_low_side_switch    <= 1'b0;
			o_short_mode         <= 1'b0;
			o_discharge_en       <= 1'b0;
			o_regulation_voltage <= VREG_RST;
			o_charge_current     <= '0;
			o_mode               <= M_CHARGE;
			o_charge_done        <= 1'b0;
			o_stat_oe            <= 1'b0;
			o_stat_out           <= 1'b0;
		end else begin
			st_ff                <= nxt_st;
			hot_ff               <= nxt_hot;
			host_ff              <= nxt_host;
			tfault_ff            <= nxt_tfault;
			nobat_ff             <= nxt_nobat;
			done_ff              <= nxt_done;
			tmr_ff               <= nxt_tmr;
			ph_ff                <= nxt_ph;
			slew_ff              <= nxt_slew;
			cur_ff               <= nxt_cur;
			pls_ff               <= nxt_pls;
			fprev_ff             <= fsel;
			fcap_ff              <= nxt_fcap;
			lock_flt_ff          <= nxt_lock_flt;
			o_pwm_en             <= charging && st_ff inside {S_SHORT, S_FAST};
			o_low_side_switch    <= charging && st_ff inside {S_SHORT, S_FAST} && ls100;
			o_short_mode         <= charging && st_ff == S_SHORT;
			o_discharge_en       <= charging && st_ff == S_DET;
			o_regulation_voltage <= host_ff ? ((vreg_ff > limv_ff) ? limv_ff : vreg_ff) : VREG_RST;
			o_charge_current     <= cur_ff;
			o_mode               <= mode;
			o_charge_done        <= done_ff;
			o_stat_oe            <= (pls_ff != 0) || (charging && ctrl_ff[B_STEN]);
			o_stat_out           <= 1'b0; // open drain, only ever pulls low
		end
	end

	assign o_rdata    = rdata_ff;
endmodule

// >>> inc/cmc_pkg.sv
// constants shared by the charger mode control logic
package cmc_pkg;

	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int          CLK_HZ     = 100_000_000; // system clock rate
	localparam int          T_DEGL_MS  = 32;          // recharge deglitch
	localparam int          T_DET_MS   = 262;         // discharge probe
	localparam int          T_EOC_MS   = 40;          // end of charge sync
	localparam int          T_PULSE_US = 128;         // fault pulse width
	localparam int          T_SLEW_US  = 1;           // ramp step period
	localparam int          T_WDOG_S   = 32;          // host watchdog
	localparam int          T_SAFE_MIN = 15;          // unattended timer
	localparam int unsigned DEGL_CYC   = T_DEGL_MS * (CLK_HZ / 1000);
	localparam int unsigned DET_CYC    = T_DET_MS * (CLK_HZ / 1000);
	localparam int unsigned EOC_CYC    = T_EOC_MS * (CLK_HZ / 1000);
	localparam int unsigned PULSE_CYC  = T_PULSE_US * (CLK_HZ / 1000000);
	localparam int unsigned SLEW_CYC   = T_SLEW_US * (CLK_HZ / 1000000);
	localparam longint unsigned WDOG_CYC = longint'(T_WDOG_S) * CLK_HZ;
	localparam longint unsigned SAFE_CYC = longint'(T_SAFE_MIN) * 60 * CLK_HZ;

	// ************************************************************
	// register map
	// ************************************************************
	localparam int       AW     = 4;     // address width
	localparam int       DW     = 16;    // data width
	localparam [3:0]     A_CTRL = 4'h0;  // control bits
	localparam [3:0]     A_VREG = 4'h1;  // regulation voltage code
	localparam [3:0]     A_ICHG = 4'h2;  // fast charge current code
	localparam [3:0]     A_LIMV = 4'h3;  // safety voltage limit
	localparam [3:0]     A_LIMI = 4'h4;  // safety current limit
	localparam [3:0]     A_STAT = 4'h5;  // live state
	localparam [3:0]     A_FLT  = 4'h6;  // frozen fault bits
	localparam int       B_INH  = 0;     // charge inhibit
	localparam int       B_HZ   = 1;     // high_impedance_request_bit
	localparam int       B_OPS  = 2;     // operation_select_bit
	localparam int       B_TERM = 3;     // termination enable
	localparam int       B_STEN = 4;     // status pin enable
	localparam int       B_PRST = 5;     // parameter reset, self clearing
	localparam [4:0]     CTRL_RST = 5'h18;
	localparam [5:0]     VREG_RST = 6'h02; // 3.54 V at 20 mV per step
	localparam [5:0]     VREG_MAX = 6'h2F; // 4.44 V
	localparam [2:0]     ICHG_RST = 3'h0;
	localparam [5:0]     LIMV_RST = 6'h0A;
	localparam [2:0]     LIMI_RST = 3'h0;

	// ************************************************************
	// fault bit positions and modes
	// ************************************************************
	localparam int F_TMR = 0, F_SLP = 1, F_OVP = 2, F_POOR = 3, F_UVLO = 4;
	localparam int F_NOBAT = 5, F_HOT = 6, F_OVLD = 7, F_BLOW = 8, NF = 9;
	localparam [NF-1:0] CHG_FLT_MASK = 9'h07F;
	localparam [NF-1:0] BST_FLT_MASK = 9'h1C5;

	typedef enum logic [1:0] {
		M_CHARGE = 2'h0,
		M_BOOST  = 2'h1,
		M_CONFIG = 2'h2,
		M_HIZ    = 2'h3
	} cmc_mode_e;

	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_SHORT = 3'h1,
		S_FAST  = 3'h2,
		S_DET   = 3'h3,
		S_EOC   = 3'h4,
		S_DONE  = 3'h5
	} cmc_state_e;

endpackage

// >>> test/cmc_top_asserts.sv
// concurrent checks on the charger mode control ports
module cmc_top_asserts #(
	parameter int unsigned P_DET_CYC = 30
) (
	// clock and reset
	input wire logic                   i_clk_sys,
	input wire logic                   i_reset,
	// inputs that outputs depend on
	input wire logic                   i_rd,
	input wire logic                   i_ls_above_100ma,
	input wire logic                   i_charge_disable_pin,
	input wire logic                   i_temp_hot,
	// watched outputs
	input wire logic [cmc_pkg::DW-1:0] o_rdata,
	input wire logic                   o_pwm_en,
	input wire logic                   o_low_side_switch,
	input wire logic                   o_discharge_en,
	input wire logic [5:0]             o_regulation_voltage,
	input wire logic [1:0]             o_mode,
	input wire logic                   o_charge_done,
	input wire logic                   o_stat_out
);
	timeunit 1ns;
	timeprecision 100ps;
	import cmc_pkg::*;

	// ************************************************************
	// helper logic
	// ************************************************************
	logic [31:0] disch_cnt_ff;  // length of the running probe
	logic [31:0] nxt_disch_cnt; // next probe length

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	// count probe cycles, zero while the probe is off
	always_comb nxt_disch_cnt = o_discharge_en ? disch_cnt_ff + 32'h1 : 32'h0;
	// register only; synchronizer lag is why checks below wait five cycles
	always_ff @(posedge i_clk_sys) disch_cnt_ff <= i_reset ? 32'h0 : nxt_disch_cnt;

	sequence s_eoc_quiet;
		(!o_charge_done)[*8];
	endsequence
	sequence s_cd_held;
		i_charge_disable_pin[*5];
	endsequence

	// ************************************************************
	// assertions
	// ************************************************************
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("read data not zero outside the answer cycle");
	ls_off_a: assert property ((!i_ls_above_100ma)[*5] |-> !o_low_side_switch)
		else $error("low side switch on below the current level");
	vreg_cap_a: assert property (o_regulation_voltage <= VREG_MAX)
		else $error("regulation voltage code above the top of range");
	disch_nopwm_a: assert property (o_discharge_en |-> !o_pwm_en)
		else $error("converter on during the discharge probe");
	disch_len_a: assert property (disch_cnt_ff <= P_DET_CYC + 2)
		else $error("discharge probe too long");
	eoc_wait_a: assert property ($fell(o_discharge_en) |-> s_eoc_quiet)
		else $error("completion shown without the sync wait");
	stat_low_a: assert property (o_stat_out == 1'b0)
		else $error("status pin driven high");
	hot_stop_a: assert property (i_temp_hot[*5] |-> !o_pwm_en)
		else $error("converter on while overheated");
	cd_hiz_a: assert property (s_cd_held |-> o_mode == M_HIZ)
		else $error("disable pin high without high impedance mode");
	cd_nopwm_a: assert property (s_cd_held |-> !o_pwm_en)
		else $error("converter on while disable pin high");
endmodule

bind cmc_top cmc_top_asserts #(.P_DET_CYC(P_DET_CYC)) u_chk (
	.i_clk_sys           (i_clk_sys),
	.i_reset             (i_reset),
	.i_rd                (i_rd),
	.i_ls_above_100ma    (i_ls_above_100ma),
	.i_charge_disable_pin(i_charge_disable_pin),
	.i_temp_hot          (i_temp_hot),
	.o_rdata             (o_rdata),
	.o_pwm_en            (o_pwm_en),
	.o_low_side_switch   (o_low_side_switch),
	.o_discharge_en      (o_discharge_en),
	.o_regulation_voltage(o_regulation_voltage),
	.o_mode              (o_mode),
	.o_charge_done       (o_charge_done),
	.o_stat_out          (o_stat_out)
);

// >>> test/cmc_host.sv
// host processor model driving the register port
module cmc_host (
	// clock
	input  wire logic                   i_clk_sys,
	// register port, host side
	input  wire logic [cmc_pkg::DW-1:0] i_rdata,
	output logic      [cmc_pkg::AW-1:0] o_addr,
	output logic      [cmc_pkg::DW-1:0] o_wdata,
	output logic                        o_wr,
	output logic                        o_rd
);
	timeunit 1ns;
	timeprecision 100ps;
	import cmc_pkg::*;

	// ************************************************************
	// bus cycles
	// ************************************************************
	initial begin
		o_addr = '0;
		o_wdata = '0;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	// one write cycle; every write also restarts the watchdog
	task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge i_clk_sys);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk_sys);
		o_wr <= 1'b0;
		// idle lines show garbage, not the last value
		o_addr <= ~a;
		o_wdata <= ~d;
		#1;
	endtask

	// one read cycle, data taken in the cycle after the strobe
	task rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
		@(posedge i_clk_sys);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk_sys);
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1;
		d = i_rdata;
	endtask
endmodule

// >>> test/cmc_top_tb.sv
// self checking bench for the charger mode control block
module cmc_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import cmc_pkg::*;

	// ************************************************************
	// signals and instances
	// ************************************************************
	localparam int DET = 30; // shortened probe
	localparam int EOC = 10; // shortened sync wait
	localparam int PW  = 8;  // shortened pulse
	logic          clk, rst, wr, rd, cd, lrst, bsh, rch, term, lowv, uvlo, hot, cool, ls;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata, rdata, d;
	logic [4:0]    flt;
	logic          pwm, lss, shm, dis, done, sout, soe;
	logic [5:0]    vreg;
	logic [2:0]    cur;
	logic [1:0]    mode;
	int            n_fail, n_checks, i, b, w;

	cmc_top #(.P_DEGL_CYC(20), .P_DET_CYC(DET), .P_EOC_CYC(EOC), .P_PULSE_CYC(PW), .P_SLEW_CYC(2),
		.P_WDOG_CYC(200), .P_SAFE_CYC(300)) dut (
		.i_clk_sys(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_charge_disable_pin(cd), .i_limit_reset_pin(lrst), .i_bat_below_short(bsh),
		.i_bat_above_rch(rch), .i_term_current(term), .i_bat_below_lowv(lowv), .i_vbus_uvlo(uvlo),
		.i_temp_hot(hot), .i_temp_cool(cool), .i_ls_above_100ma(ls), .i_flt(flt), .o_pwm_en(pwm),
		.o_low_side_switch(lss), .o_short_mode(shm), .o_discharge_en(dis), .o_regulation_voltage(vreg),
		.o_charge_current(cur), .o_mode(mode), .o_charge_done(done), .o_stat_out(sout), .o_stat_oe(soe));
	cmc_host host (.i_clk_sys(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

	// ************************************************************
	// tasks
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// wait n edges, then settle so outputs can be read
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// width of the next status pulse, zero if none starts
	task pw(output int n);
		n = 0;
		for (int k = 0; k < 10 && soe !== 1'b1; k++) cyc(1);
		while (soe === 1'b1 && n < 20) begin
			n++;
			cyc(1);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		{rst, lowv, bsh, ls} = 4'hF;
		{cd, lrst, rch, term, uvlo, hot, cool} = 7'h00;
		flt = 5'h00;
		cyc(5);
		rst <= 1'b0;
		cyc(6);
		chk("mode", 16'(M_CHARGE), 16'(mode));
		chk("short", 16'h0003, 16'({pwm, shm}));
		chk("vreg", 16'(VREG_RST), 16'(vreg));
		host.wr(A_LIMV, 16'h0005);
		host.rd(A_LIMV, d);
		chk("limv pin low", 16'(LIMV_RST), d);
		// second reset with the limit pin released
		{lrst, rst} <= 2'b11;
		cyc(5);
		rst <= 1'b0;
		cyc(6);
		host.wr(A_LIMV, 16'h0005);
		host.wr(A_VREG, 16'h002F);
		host.wr(A_LIMV, 16'h0020);
		host.wr(A_ICHG, 16'h0007);
		host.rd(A_LIMV, d);
		chk("limv locked", 16'h0005, d);
		host.rd(4'hF, d);
		chk("unmapped", 16'h0000, d);
		bsh <= 1'b0;
		cyc(8);
		chk("vreg cap", 16'h0005, 16'(vreg));
		chk("current cap", 16'h0000, 16'(cur));
		chk("fast", 16'h0002, 16'({pwm, shm}));
		chk("stat low", 16'h0001, 16'(soe));
		ls <= 1'b0;
		cyc(6);
		chk("ls off", 16'h0000, 16'(lss));
		ls <= 1'b1;
		cyc(6);
		chk("ls on", 16'h0001, 16'(lss));
		host.wr(A_CTRL, 16'h0010);
		{rch, term} <= 2'b11;
		cyc(40);
		chk("no term", 16'h0001, 16'({dis, pwm}));
		host.wr(A_CTRL, 16'h0018);
		for (i = 0; i < 60 && dis !== 1'b1; i++) cyc(1);
		chk("probe", 16'h0002, 16'({dis, pwm}));
		for (i = 0; i < 60 && done !== 1'b1; i++) cyc(1);
		chk("done", 16'h0001, 16'(done && i >= DET + EOC - 1));
		host.rd(A_STAT, d);
		chk("stat reg", 16'h0053, d & 16'h0073);
		rch <= 1'b0;
		cyc(8);
		chk("recharge", 16'h0001, 16'({done, pwm}));
		// battery pulled away during the probe
		host.wr(A_CTRL, 16'h0018);
		rch <= 1'b1;
		for (i = 0; i < 60 && dis !== 1'b1; i++) cyc(1);
		rch <= 1'b0;
		for (i = 0; i < 60 && dis !== 1'b0; i++) cyc(1);
		cyc(12);
		host.rd(A_FLT, d);
		chk("removed", 16'h0020, (d & 16'h0020) | 16'(done));
		term <= 1'b0;
		host.wr(A_CTRL, 16'h0008);
		cyc(6);
		chk("stat open", 16'h0000, 16'(soe));
		flt <= 5'h08;
		pw(w);
		flt <= 5'h00;
		chk("masked", 16'h0000, 16'(w));
		// each of the five flt bits once, a second fault lands mid pulse
		for (b = 0; b < 5; b++) begin
			host.wr(A_CTRL, (b < 3) ? 16'h0008 : 16'h000C);
			cyc(6);
			if (b == 3) chk("boost", 16'(M_BOOST), 16'(mode));
			flt <= 5'h01 << b;
			fork
				pw(w);
				begin
					cyc(6);
					flt[(b < 3) ? (b + 1) % 3 : 7 - b] <= 1'b1;
					cyc(1);
					chk("configure", 16'(M_CONFIG), 16'(mode));
					flt <= 5'h00;
				end
			join
			chk("pulse", 16'(PW), 16'(w));
		end
		for (b = 0; b < 4; b++) begin
			host.wr(A_CTRL, 16'h0008 | 16'(b << 1));
			cyc(6);
			chk("mode table", 16'(b[0] ? M_HIZ : b[1] ? M_BOOST : M_CHARGE), 16'(mode));
		end
		host.wr(A_CTRL, 16'h0008);
		uvlo <= 1'b1;
		cyc(6);
		chk("uvlo", 16'(M_HIZ), 16'(mode));
		{uvlo, cd} <= 2'b01;
		cyc(6);
		chk("cd pin", 16'(M_HIZ), 16'(mode));
		{cd, bsh} <= 2'b01;
		host.wr(A_CTRL, 16'h0009);
		cyc(6);
		chk("inhibit", 16'h0000, 16'(pwm));
		host.wr(A_CTRL, 16'h0008);
		cyc(6);
		chk("restart", 16'h0003, 16'({pwm, shm}));
		hot <= 1'b1;
		cyc(6);
		chk("hot", 16'h0000, 16'(pwm));
		{hot, cool} <= 2'b01;
		cyc(6);
		chk("cool", 16'h0001, 16'(pwm));
		// parameter reset bit written while charging is stopped
		cd <= 1'b1;
		host.wr(A_VREG, 16'h0010);
		host.wr(A_CTRL, 16'h0028);
		host.rd(A_VREG, d);
		chk("prst vreg", 16'(VREG_RST), d);
		host.rd(A_CTRL, d);
		chk("prst ctrl", 16'(CTRL_RST), d);
		cd <= 1'b0;
		cyc(250);
		host.rd(A_STAT, d);
		chk("watchdog", 16'h0000, d & 16'h0002);
		final_report;
	end

	// hang guard, far beyond the expected run length
	initial begin
		repeat (10000) @(posedge clk);
		n_fail++;
		final_report;
	end
endmodule
